// ---- hdl/pem_perf_monitor.sv ----
// Walk controller and buffer unit performance monitors
`timescale 1ns/1ps
`default_nettype none
`include "pem_params.svh"
module pem_perf_monitor #(
  parameter int NUM_BUF = `PEM_NUM_BUF,
  parameter int NUM_CNT = `PEM_NUM_CNT,
  parameter int CNT_W   = `PEM_CNT_W,
  parameter int SID_W   = `PEM_SID_W
) (
  // Clock and reset
  input  wire logic                            CLK_I,
  input  wire logic                            RESET_I,
  // Walk controller events
  input  wire logic                            WALK_CLK_GATED_I,
  input  wire logic                            WALK_REQ_BUF_VALID_I,
  input  wire logic [SID_W-1:0]                WALK_REQ_BUF_SID_I,
  input  wire logic                            WALK_REQ_ATS_VALID_I,
  input  wire logic [SID_W-1:0]                WALK_REQ_ATS_SID_I,
  input  wire logic                            WALK_TT_MISS_I,
  input  wire logic [SID_W-1:0]                WALK_TT_MISS_SID_I,
  input  wire logic                            WALK_CFG_MISS_I,
  input  wire logic [SID_W-1:0]                WALK_CFG_MISS_SID_I,
  input  wire logic                            WALK_TT_ACCESS_I,
  input  wire logic [SID_W-1:0]                WALK_TT_ACCESS_SID_I,
  input  wire logic                            WALK_CFG_ACCESS_I,
  input  wire logic [SID_W-1:0]                WALK_CFG_ACCESS_SID_I,
  input  wire logic [`PEM_WC_LEVELS-1:0]       WALK_S1_LOOKUP_I,
  input  wire logic [`PEM_WC_LEVELS-1:0]       WALK_S1_MISS_I,
  input  wire logic [`PEM_WC_LEVELS-1:0]       WALK_S2_LOOKUP_I,
  input  wire logic [`PEM_WC_LEVELS-1:0]       WALK_S2_MISS_I,
  input  wire logic [SID_W-1:0]                WALK_CACHE_SID_I,
  // Walk controller filter and counters
  input  wire logic                            WALK_FILTER_EN_I,
  input  wire logic [SID_W-1:0]                WALK_FILTER_SID_I,
  input  wire logic [NUM_CNT*`PEM_CODE_W-1:0]  WALK_EVENT_SEL_I,
  output logic [NUM_CNT*CNT_W-1:0]             WALK_COUNT_O,
  // Buffer unit events, one lane per unit
  input  wire logic [NUM_BUF-1:0]              BUF_CLK_GATED_I,
  input  wire logic [NUM_BUF-1:0]              BUF_ISSUE_VALID_I,
  input  wire logic [NUM_BUF-1:0]              BUF_ISSUE_ATS_I,
  input  wire logic [NUM_BUF*SID_W-1:0]        BUF_ISSUE_SID_I,
  input  wire logic [NUM_BUF-1:0]              BUF_WREQ_VALID_I,
  input  wire logic [NUM_BUF-1:0]              BUF_WREQ_SPEC_I,
  input  wire logic [NUM_BUF*SID_W-1:0]        BUF_WREQ_SID_I,
  // Buffer unit filters and counters
  input  wire logic [NUM_BUF-1:0]              BUF_FILTER_EN_I,
  input  wire logic [NUM_BUF*SID_W-1:0]        BUF_FILTER_SID_I,
  input  wire logic [NUM_BUF*NUM_CNT*`PEM_CODE_W-1:0] BUF_EVENT_SEL_I,
  output logic [NUM_BUF*NUM_CNT*CNT_W-1:0]     BUF_COUNT_O
);
  localparam int LV     = `PEM_WC_LEVELS;
  localparam int CODES  = `PEM_CODE_SPACE;
  localparam int CW     = `PEM_CODE_W;
  localparam int S_CYC  = 0;
  localparam int S_BREQ = 1;
  localparam int S_AREQ = 2;
  localparam int S_TTM  = 3;
  localparam int S_CFM  = 4;
  localparam int S_TTA  = 5;
  localparam int S_CFA  = 6;
  localparam int S_WC   = 7;
  localparam int NWS    = S_WC + 4 * LV;
  localparam int B_CYC  = 0;
  localparam int B_ISS  = 1;
  localparam int B_ATS  = 2;
  localparam int B_WRQ  = 3;
  localparam int NBS    = 4;

  // Walk controller event slots
  logic [NWS-1:0]   wv;
  logic [NWS-1:0]   wf;
  logic [SID_W-1:0] ws [NWS];
  logic [NWS-1:0]   wq;
  logic [CODES-1:0] wqa;
  logic [CODES-1:0] wqb;

  always_comb
  begin
    wf = '1;
    wf[S_CYC] = 1'b0;
    wv[S_CYC] = !WALK_CLK_GATED_I;
    ws[S_CYC] = '0;
    // Each arrival is taken as it comes; a restart simply arrives again
    wv[S_BREQ] = WALK_REQ_BUF_VALID_I;
    ws[S_BREQ] = WALK_REQ_BUF_SID_I;
    wv[S_AREQ] = WALK_REQ_ATS_VALID_I;
    ws[S_AREQ] = WALK_REQ_ATS_SID_I;
    wv[S_TTM] = WALK_TT_MISS_I;
    ws[S_TTM] = WALK_TT_MISS_SID_I;
    wv[S_CFM] = WALK_CFG_MISS_I;
    ws[S_CFM] = WALK_CFG_MISS_SID_I;
    wv[S_TTA] = WALK_TT_ACCESS_I;
    ws[S_TTA] = WALK_TT_ACCESS_SID_I;
    wv[S_CFA] = WALK_CFG_ACCESS_I;
    ws[S_CFA] = WALK_CFG_ACCESS_SID_I;
    for (int l = 0; l < LV; l++)
    begin
      wv[S_WC + l] = WALK_S1_LOOKUP_I[l];
      wv[S_WC + LV + l] = WALK_S1_MISS_I[l];
      wv[S_WC + 2 * LV + l] = WALK_S2_LOOKUP_I[l];
      wv[S_WC + 3 * LV + l] = WALK_S2_MISS_I[l];
      ws[S_WC + l] = WALK_CACHE_SID_I;
      ws[S_WC + LV + l] = WALK_CACHE_SID_I;
      ws[S_WC + 2 * LV + l] = WALK_CACHE_SID_I;
      ws[S_WC + 3 * LV + l] = WALK_CACHE_SID_I;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NWS; gi++)
    begin : g_wflt
      pem_sid_filter #(
        .SID_W (SID_W)
      ) u_flt (
        .valid_i      (wv[gi]),
        .sid_i        (ws[gi]),
        .filterable_i (wf[gi]),
        .filt_en_i    (WALK_FILTER_EN_I),
        .filt_sid_i   (WALK_FILTER_SID_I),
        .qual_o       (wq[gi])
      );
    end
  endgenerate

  // Code map; both request sources may land on code 1 in one cycle
  always_comb
  begin
    wqa = '0;
    wqb = '0;
    wqa[`PEM_EV_CYCLES] = wq[S_CYC];
    wqa[`PEM_EV_XACT] = wq[S_BREQ];
    wqb[`PEM_EV_XACT] = wq[S_AREQ];
    wqa[`PEM_EV_TT_MISS] = wq[S_TTM];
    wqa[`PEM_EV_CFG_MISS] = wq[S_CFM];
    wqa[`PEM_EV_TT_ACCESS] = wq[S_TTA];
    wqa[`PEM_EV_CFG_ACCESS] = wq[S_CFA];
    wqa[`PEM_EV_ATS_REQ] = wq[S_AREQ];
    for (int l = 0; l < LV; l++)
    begin
      wqa[`PEM_EV_S1_LOOKUP + 8'(l) * `PEM_EV_LEVEL_STEP] = wq[S_WC + l];
      wqa[`PEM_EV_S1_LOOKUP + 8'(l) * `PEM_EV_LEVEL_STEP + `PEM_EV_MISS_OFS] =
        wq[S_WC + LV + l];
      wqa[`PEM_EV_S2_LOOKUP + 8'(l) * `PEM_EV_LEVEL_STEP] = wq[S_WC + 2 * LV + l];
      wqa[`PEM_EV_S2_LOOKUP + 8'(l) * `PEM_EV_LEVEL_STEP + `PEM_EV_MISS_OFS] =
        wq[S_WC + 3 * LV + l];
    end
  end

  // Walk controller monitor counters
  genvar gk;
  generate
    for (gk = 0; gk < NUM_CNT; gk++)
    begin : g_wcnt
      pem_event_counter #(
        .CNT_W (CNT_W),
        .CODES (CODES)
      ) u_cnt (
        .clk_i   (CLK_I),
        .rst_i   (RESET_I),
        .qa_i    (wqa),
        .qb_i    (wqb),
        .sel_i   (WALK_EVENT_SEL_I[gk*CW +: CW]),
        .count_o (WALK_COUNT_O[gk*CNT_W +: CNT_W])
      );
    end
  endgenerate

  // One separate monitor per buffer unit
  genvar gt;
  genvar gj;
  generate
    for (gt = 0; gt < NUM_BUF; gt++)
    begin : g_buf
      logic [NBS-1:0]   bv;
      logic [NBS-1:0]   bf;
      logic [SID_W-1:0] bs [NBS];
      logic [NBS-1:0]   bq;
      logic [CODES-1:0] bqa;

      always_comb
      begin
        bf = '1;
        bf[B_CYC] = 1'b0;
        bv[B_CYC] = !BUF_CLK_GATED_I[gt];
        bs[B_CYC] = '0;
        bv[B_ISS] = BUF_ISSUE_VALID_I[gt];
        bs[B_ISS] = BUF_ISSUE_SID_I[gt*SID_W +: SID_W];
        bv[B_ATS] = BUF_ISSUE_VALID_I[gt] && BUF_ISSUE_ATS_I[gt];
        bs[B_ATS] = BUF_ISSUE_SID_I[gt*SID_W +: SID_W];
        bv[B_WRQ] = BUF_WREQ_VALID_I[gt] && !BUF_WREQ_SPEC_I[gt];
        bs[B_WRQ] = BUF_WREQ_SID_I[gt*SID_W +: SID_W];
      end

      for (gj = 0; gj < NBS; gj++)
      begin : g_bflt
        pem_sid_filter #(
          .SID_W (SID_W)
        ) u_flt (
          .valid_i      (bv[gj]),
          .sid_i        (bs[gj]),
          .filterable_i (bf[gj]),
          .filt_en_i    (BUF_FILTER_EN_I[gt]),
          .filt_sid_i   (BUF_FILTER_SID_I[gt*SID_W +: SID_W]),
          .qual_o       (bq[gj])
        );
      end

      always_comb
      begin
        bqa = '0;
        bqa[`PEM_EV_CYCLES] = bq[B_CYC];
        bqa[`PEM_EV_XACT] = bq[B_ISS];
        bqa[`PEM_EV_TT_MISS] = bq[B_WRQ];
        bqa[`PEM_EV_ATS_XACT] = bq[B_ATS];
      end

      for (gj = 0; gj < NUM_CNT; gj++)
      begin : g_bcnt
        pem_event_counter #(
          .CNT_W (CNT_W),
          .CODES (CODES)
        ) u_cnt (
          .clk_i   (CLK_I),
          .rst_i   (RESET_I),
          .qa_i    (bqa),
          .qb_i    ({CODES{1'b0}}),
          .sel_i   (BUF_EVENT_SEL_I[(gt*NUM_CNT+gj)*CW +: CW]),
          .count_o (BUF_COUNT_O[(gt*NUM_CNT+gj)*CNT_W +: CNT_W])
        );
      end
    end
  endgenerate

  // Checks watch counter 0 of the walk monitor and of buffer unit 0
  pem_pkg::pem_code_t wsel0;
  pem_pkg::pem_code_t bsel0;
  logic [CNT_W-1:0]   wcnt0;
  logic [CNT_W-1:0]   bcnt0;
  assign wsel0 = WALK_EVENT_SEL_I[CW-1:0];
  assign bsel0 = BUF_EVENT_SEL_I[CW-1:0];
  assign wcnt0 = WALK_COUNT_O[CNT_W-1:0];
  assign bcnt0 = BUF_COUNT_O[CNT_W-1:0];

  chk_cycle_count :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_CYCLES && !WALK_CLK_GATED_I) [*2] |=> (wcnt0 == $past(wcnt0, 2) + 2'd2))
    else $error("cycle event not counted");
  chk_gated_hold :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_CYCLES && WALK_CLK_GATED_I) |=> $stable(wcnt0))
    else $error("gated cycle counted");
  chk_req_dual :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_XACT && !WALK_FILTER_EN_I && WALK_REQ_BUF_VALID_I && WALK_REQ_ATS_VALID_I)
    |=> (wcnt0 == $past(wcnt0) + CNT_W'(2)))
    else $error("dual request not counted twice");
  chk_tt_miss :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_TT_MISS && !WALK_FILTER_EN_I && WALK_TT_MISS_I)
    |=> (wcnt0 == $past(wcnt0) + 1'b1))
    else $error("table walk miss not counted");
  chk_cfg_access :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_CFG_ACCESS && !WALK_FILTER_EN_I && WALK_CFG_ACCESS_I)
    |=> (wcnt0 == $past(wcnt0) + 1'b1))
    else $error("config access not counted");
  chk_ats_only :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_ATS_REQ && WALK_REQ_BUF_VALID_I && !WALK_REQ_ATS_VALID_I)
    |=> $stable(wcnt0))
    else $error("buffer request counted as ATS");
  chk_s1_miss_l3 :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == 8'h87 && !WALK_FILTER_EN_I && WALK_S1_MISS_I[3])
    |=> (wcnt0 == $past(wcnt0) + 1'b1))
    else $error("stage-1 level 3 miss not counted");
  chk_s2_lookup_l1 :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == 8'h8A && !WALK_FILTER_EN_I && WALK_S2_LOOKUP_I[1])
    |=> (wcnt0 == $past(wcnt0) + 1'b1))
    else $error("stage-2 level 1 lookup not counted");
  chk_filter_block :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (wsel0 == `PEM_EV_XACT && WALK_FILTER_EN_I && !WALK_REQ_ATS_VALID_I &&
     WALK_REQ_BUF_SID_I != WALK_FILTER_SID_I) |=> $stable(wcnt0))
    else $error("filtered request counted");
  chk_spec_skip :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (bsel0 == `PEM_EV_TT_MISS && BUF_WREQ_SPEC_I[0]) |=> $stable(bcnt0))
    else $error("speculative request counted");
  chk_ats_issue :
  assert property (@(posedge CLK_I) disable iff (RESET_I)
    (bsel0 == `PEM_EV_ATS_XACT && !BUF_FILTER_EN_I[0] && BUF_ISSUE_VALID_I[0] &&
     BUF_ISSUE_ATS_I[0]) |=> (bcnt0 == $past(bcnt0) + 1'b1))
    else $error("translated issue not counted");

  cov_dual_req :
  cover property (@(posedge CLK_I) disable iff (RESET_I)
    wsel0 == `PEM_EV_XACT && WALK_REQ_BUF_VALID_I && WALK_REQ_ATS_VALID_I);
  cov_filter_match :
  cover property (@(posedge CLK_I) disable iff (RESET_I)
    WALK_FILTER_EN_I && WALK_S1_LOOKUP_I[0] && WALK_CACHE_SID_I == WALK_FILTER_SID_I);
  cov_gated :
  cover property (@(posedge CLK_I) disable iff (RESET_I)
    wsel0 == `PEM_EV_CYCLES && WALK_CLK_GATED_I);
  cov_buf_ats :
  cover property (@(posedge CLK_I) disable iff (RESET_I)
    bsel0 == `PEM_EV_ATS_XACT && BUF_ISSUE_VALID_I[0] && BUF_ISSUE_ATS_I[0]);
endmodule
`default_nettype wire

// ---- include/pem_params.svh ----
// Event codes, widths and default sizes for the performance monitors
`ifndef PEM_PARAMS_SVH
`define PEM_PARAMS_SVH
`define PEM_CODE_W 8
`define PEM_CODE_SPACE 256
`define PEM_SID_W 24
`define PEM_CNT_W 32
`define PEM_NUM_CNT 4
`define PEM_NUM_BUF 2
`define PEM_WC_LEVELS 4
`define PEM_EV_CYCLES 8'h00
`define PEM_EV_XACT 8'h01
`define PEM_EV_TT_MISS 8'h02
`define PEM_EV_CFG_MISS 8'h03
`define PEM_EV_TT_ACCESS 8'h04
`define PEM_EV_CFG_ACCESS 8'h05
`define PEM_EV_ATS_REQ 8'h06
`define PEM_EV_ATS_XACT 8'h07
`define PEM_EV_S1_LOOKUP 8'h80
`define PEM_EV_S2_LOOKUP 8'h88
`define PEM_EV_MISS_OFS 8'h01
`define PEM_EV_LEVEL_STEP 8'h02
`endif

// ---- include/pem_pkg.sv ----
// Types shared by the performance monitor files
`include "pem_params.svh"
package pem_pkg;
  typedef logic [`PEM_CODE_W-1:0] pem_code_t;
  typedef logic [1:0] pem_inc_t;
endpackage

// ---- hdl/pem_sid_filter.sv ----
// StreamID qualifier for one event source
`timescale 1ns/1ps
`default_nettype none
`include "pem_params.svh"
module pem_sid_filter #(
  parameter int SID_W = `PEM_SID_W
) (
  // Event
  input  wire logic             valid_i,
  input  wire logic [SID_W-1:0] sid_i,
  input  wire logic             filterable_i,
  // Filter setting
  input  wire logic             filt_en_i,
  input  wire logic [SID_W-1:0] filt_sid_i,
  // Result
  output logic                  qual_o
);
  // Speculative or faulting activity is not exempt
  assign qual_o = valid_i && (!filterable_i || !filt_en_i || (sid_i == filt_sid_i));
endmodule
`default_nettype wire

// ---- hdl/pem_event_counter.sv ----
// One event counter with its event code select
`timescale 1ns/1ps
`default_nettype none
`include "pem_params.svh"
module pem_event_counter #(
  parameter int CNT_W = `PEM_CNT_W,
  parameter int CODES = `PEM_CODE_SPACE
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Qualified events by code, two sources per code
  input  wire logic [CODES-1:0]     qa_i,
  input  wire logic [CODES-1:0]     qb_i,
  input  wire pem_pkg::pem_code_t   sel_i,
  // Count
  output logic [CNT_W-1:0]          count_o
);
  pem_pkg::pem_inc_t inc;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  count_d;

  // Unused codes are zero in both vectors
  always_comb
  begin
    inc = {1'b0, qa_i[sel_i]} + {1'b0, qb_i[sel_i]};
    count_d = count_q + CNT_W'(inc);
  end

  // Wraps silently; software reads differences
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign count_o = count_q;

  chk_idle_hold :
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!qa_i[sel_i] && !qb_i[sel_i]) |=> $stable(count_o))
    else $error("counter moved without its event");
  chk_double_step :
  assert property (@(posedge clk_i) disable iff (rst_i)
    (qa_i[sel_i] && qb_i[sel_i]) |=> (count_o == $past(count_o) + CNT_W'(2)))
    else $error("two occurrences not added");
  chk_reset_clear :
  assert property (@(posedge clk_i) rst_i |=> (count_o == '0))
    else $error("counter not cleared by reset");
endmodule
`default_nettype wire

// ---- bench/pem_perf_monitor_tb_top.sv ----
// Self-checking bench for the walk and buffer unit performance monitors
`timescale 1ns/1ps
`default_nettype none
module pem_perf_monitor_tb_top;
  logic         clk, rst, wg, rbv, rav, tm, cm, ta, ca, wfe;
  logic [23:0]  rbs, ras, tms, cms, tas, cas, wcs, wfs;
  logic [3:0]   s1l, s1m, s2l, s2m;
  logic [31:0]  wsel;
  logic [127:0] wcnt;
  logic [1:0]   bg, biv, bia, bwv, bwp, bfe;
  logic [47:0]  bis, bws, bfs;
  logic [63:0]  bsel;
  logic [255:0] bcnt;
  int           bad_count, total_checks;
  int           cyc = 0;

  pem_perf_monitor DUT (
    .CLK_I(clk), .RESET_I(rst), .WALK_CLK_GATED_I(wg),
    .WALK_REQ_BUF_VALID_I(rbv), .WALK_REQ_BUF_SID_I(rbs),
    .WALK_REQ_ATS_VALID_I(rav), .WALK_REQ_ATS_SID_I(ras),
    .WALK_TT_MISS_I(tm), .WALK_TT_MISS_SID_I(tms),
    .WALK_CFG_MISS_I(cm), .WALK_CFG_MISS_SID_I(cms),
    .WALK_TT_ACCESS_I(ta), .WALK_TT_ACCESS_SID_I(tas),
    .WALK_CFG_ACCESS_I(ca), .WALK_CFG_ACCESS_SID_I(cas),
    .WALK_S1_LOOKUP_I(s1l), .WALK_S1_MISS_I(s1m),
    .WALK_S2_LOOKUP_I(s2l), .WALK_S2_MISS_I(s2m),
    .WALK_CACHE_SID_I(wcs), .WALK_FILTER_EN_I(wfe),
    .WALK_FILTER_SID_I(wfs), .WALK_EVENT_SEL_I(wsel),
    .WALK_COUNT_O(wcnt), .BUF_CLK_GATED_I(bg),
    .BUF_ISSUE_VALID_I(biv), .BUF_ISSUE_ATS_I(bia),
    .BUF_ISSUE_SID_I(bis), .BUF_WREQ_VALID_I(bwv),
    .BUF_WREQ_SPEC_I(bwp), .BUF_WREQ_SID_I(bws),
    .BUF_FILTER_EN_I(bfe), .BUF_FILTER_SID_I(bfs),
    .BUF_EVENT_SEL_I(bsel), .BUF_COUNT_O(bcnt)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] wc(input int k);
    return wcnt[k*32 +: 32];
  endfunction

  function automatic logic [31:0] bc(input int t, input int k);
    return bcnt[(t*4+k)*32 +: 32];
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: %s saw %0h expected %0h", $time, m, s, e);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      final_report();
    end
  end

  // Events off and clocks gated, so idle cycles never count
  task automatic quiet();
    wg <= 1'b1;
    bg <= 2'h3;
    {rbv, rav, tm, cm, ta, ca} <= 6'h00;
    {s1l, s1m, s2l, s2m} <= 16'h0000;
    {biv, bia, bwv, bwp} <= 8'h00;
  endtask

  task automatic rs();
    @(posedge clk);
    quiet();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic t_cycles();
    rs();
    wsel <= 32'h0000_0100;
    wfe <= 1'b1;
    wfs <= 24'h000005;
    bsel <= 64'h0;
    bfe <= 2'h3;
    bfs <= {24'h000009, 24'h000009};
    @(posedge clk);
    wg <= 1'b0;
    bg <= 2'h0;
    repeat (5) @(posedge clk);
    bg <= 2'h1;
    @(posedge clk);
    wg <= 1'b1;
    repeat (2) @(posedge clk);
    wg <= 1'b0;
    bg <= 2'h3;
    repeat (3) @(posedge clk);
    wg <= 1'b1;
    @(negedge clk);
    chk(wc(0), 32'h9, "walk cycles");
    chk(wc(1), 32'h0, "walk idle req");
    chk(bc(0, 0), 32'h5, "buf0 cycles");
    chk(bc(1, 0), 32'h8, "buf1 cycles");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(wc(0), 32'h0, "reset clear");
    @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic t_walk();
    rs();
    wsel <= 32'h0603_0201;
    wfe <= 1'b1;
    wfs <= 24'h00ABCD;
    @(posedge clk);
    {rbv, rav} <= 2'h3;
    rbs <= 24'h00ABCD;
    ras <= 24'h00ABCD;
    @(posedge clk);
    ras <= 24'h00ABCE;
    @(posedge clk);
    rbv <= 1'b0;
    ras <= 24'h00ABCD;
    @(posedge clk);
    rav <= 1'b0;
    {tm, cm} <= 2'h3;
    tms <= 24'h00ABCD;
    cms <= 24'h00ABCE;
    @(posedge clk);
    tms <= 24'h00ABCE;
    cms <= 24'h00ABCD;
    @(posedge clk);
    tm <= 1'b0;
    @(posedge clk);
    quiet();
    @(negedge clk);
    chk(wc(0), 32'h4, "requests");
    chk(wc(1), 32'h1, "table miss");
    chk(wc(2), 32'h2, "config miss");
    chk(wc(3), 32'h2, "ats requests");
    rs();
    wsel <= 32'h0106_0504;
    wfe <= 1'b0;
    @(posedge clk);
    {ta, ca} <= 2'h3;
    @(posedge clk);
    ca <= 1'b0;
    rav <= 1'b1;
    @(posedge clk);
    {ta, rav, rbv} <= 3'h1;
    @(posedge clk);
    quiet();
    @(negedge clk);
    chk(wc(0), 32'h2, "table access");
    chk(wc(1), 32'h1, "config access");
    chk(wc(2), 32'h1, "ats unfiltered");
    chk(wc(3), 32'h2, "req unfiltered");
  endtask

  // Each stage-1 level gets a different lookup and miss count, so a swapped stage-1 level shows
  task automatic t_cache();
    logic [7:0] b;
    for (int l = 0; l < 4; l++)
    begin
      rs();
      b = 8'h80 + 8'(2 * l);
      wsel <= {b + 8'h09, b + 8'h08, b + 8'h01, b};
      wfe <= 1'b1;
      wfs <= 24'h000777;
      wcs <= 24'h000777;
      for (int i = 0; i < 4; i++)
      begin
        @(posedge clk);
        s1l <= 4'hF << i;
        s1m <= 4'hF >> i;
        s2l <= 4'h1 << i;
        s2m <= (4'hF << i) & 4'h3;
      end
      @(posedge clk);
      {s1l, s1m, s2l, s2m} <= 16'hFFFF;
      wcs <= 24'h000778;
      @(posedge clk);
      quiet();
      @(negedge clk);
      chk(wc(0), 32'(l + 1), "s1 lookup");
      chk(wc(1), 32'(4 - l), "s1 miss");
      chk(wc(2), 32'h1, "s2 lookup");
      chk(wc(3), (l < 2) ? 32'(l + 1) : 32'h0, "s2 miss");
    end
  endtask

  task automatic t_buf();
    int e0[4] = '{1, 1, 1, 0};
    int e1[4] = '{2, 2, 1, 0};
    rs();
    bsel <= 64'hFF07_0201_0807_0201;
    bfe <= 2'h1;
    bfs <= {24'h000000, 24'h000012};
    @(posedge clk);
    biv <= 2'h3;
    bia <= 2'h1;
    bis <= {24'h000005, 24'h000012};
    @(posedge clk);
    bia <= 2'h2;
    bis <= {24'h000005, 24'h000013};
    @(posedge clk);
    {biv, bia, bwp} <= 6'h00;
    bwv <= 2'h3;
    bws <= {24'h000005, 24'h000012};
    @(posedge clk);
    bwp <= 2'h3;
    @(posedge clk);
    bwp <= 2'h0;
    bws <= {24'h000005, 24'h000013};
    @(posedge clk);
    quiet();
    @(negedge clk);
    for (int k = 0; k < 4; k++)
    begin
      chk(bc(0, k), 32'(e0[k]), "buf0 count");
      chk(bc(1, k), 32'(e1[k]), "buf1 count");
    end
  endtask

  task automatic t_unimpl();
    rs();
    wsel <= 32'hFF7F_0807;
    wfe <= 1'b0;
    @(posedge clk);
    {rbv, rav, tm, cm, ta, ca} <= 6'h3F;
    {s1l, s1m, s2l, s2m} <= 16'hFFFF;
    wg <= 1'b0;
    repeat (4) @(posedge clk);
    quiet();
    @(negedge clk);
    for (int k = 0; k < 4; k++)
      chk(wc(k), 32'h0, "unused code");
  endtask

  // Counter 0 of the walk monitor and of buffer unit 0 steps through the codes its checks watch, all but the walk cycle code
  task automatic t_sel0();
    rs();
    {wfe, bfe} <= 3'h0;
    @(posedge clk);
    wsel <= 32'h0000_0001;
    bsel <= 64'h0000_0000_0000_0007;
    {rbv, rav} <= 2'h3;
    {biv, bia} <= 4'h5;
    @(posedge clk);
    wsel <= 32'h0000_0002;
    bsel <= 64'h0000_0000_0000_0002;
    {rbv, rav, tm} <= 3'h1;
    {biv, bia, bwv, bwp} <= 8'h05;
    @(posedge clk);
    wsel <= 32'h0000_0005;
    {tm, ca} <= 2'h1;
    bwp <= 2'h0;
    @(posedge clk);
    wsel <= 32'h0000_0006;
    {ca, rbv} <= 2'h1;
    bwv <= 2'h0;
    @(posedge clk);
    wsel <= 32'h0000_0001;
    wfe <= 1'b1;
    wfs <= 24'h000042;
    rbs <= 24'h000041;
    @(posedge clk);
    wsel <= 32'h0000_0087;
    wfe <= 1'b0;
    rbv <= 1'b0;
    s1m <= 4'h8;
    @(posedge clk);
    wsel <= 32'h0000_008A;
    s1m <= 4'h0;
    s2l <= 4'h2;
    @(posedge clk);
    quiet();
    @(negedge clk);
    chk(wc(0), 32'h6, "walk steps");
    chk(bc(0, 0), 32'h2, "buf0 steps");
  endtask

  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst = 1'b1;
    wg = 1'b1;
    bg = 2'h3;
    {rbv, rav, tm, cm, ta, ca, wfe} = 7'h00;
    {s1l, s1m, s2l, s2m, biv, bia, bwv, bwp, bfe} = 26'h0;
    {rbs, ras, tms, cms, tas, cas, wcs, wfs} = 192'h0;
    {bis, bws, bfs} = 144'h0;
    wsel = 32'h0;
    bsel = 64'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_cycles();
    t_walk();
    t_cache();
    t_buf();
    t_unimpl();
    t_sel0();
    final_report();
  end
endmodule
`default_nettype wire
